/* File: rtl/eag_core.sv */
// Purpose: Effective address and operand generation between decoder and bus controller
// Assumes: Fetch port returns exactly one long word per request, held until accepted
// Notes:   One request in flight; start is ignored while busy
`timescale 1ns/100ps
`default_nettype none

module eag_core
   import eag_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Decoded request
   input  wire logic             start,
   input  wire eag_mode_t        mode,
   input  wire eag_size_t        op_size,
   input  wire logic [2:0]       reg_num,
   input  wire logic [REG_SEL_W-1:0] index_sel,
   input  wire logic             index_long,
   input  wire logic [1:0]       index_scale,
   input  wire logic [7:0]       short_disp,
   input  wire logic [15:0]      word_disp,
   input  wire eag_ofs_t         base_offset_size,
   input  wire logic [31:0]      base_offset,
   input  wire eag_ofs_t         outer_offset_size,
   input  wire logic [31:0]      outer_offset,
   input  wire logic [31:0]      ext_word,
   input  wire logic [AW-1:0]    pc,
   // Register file view
   input  wire logic [8*32-1:0]  data_reg,
   input  wire logic [8*32-1:0]  address_reg,
   // Bit-field and decimal typing
   input  wire logic [4:0]       field_offset,
   input  wire logic [4:0]       field_len_m1,
   input  wire logic             bcd_packed,
   // Indirect fetch port
   output logic                  fetch_req,
   output logic [AW-1:0]         fetch_addr,
   input  wire logic             fetch_ack,
   input  wire logic [31:0]      fetch_data,
   // Results
   output logic                  busy,
   output logic                  done,
   output logic                  is_register,
   output logic                  is_immediate,
   output logic [AW-1:0]         ea,
   output logic [63:0]           operand,
   output logic                  areg_write,
   output logic [2:0]            areg_num,
   output logic [31:0]           areg_value,
   output logic [31:0]           field_value,
   output logic [7:0]            bcd_value
);

   typedef enum logic [1:0] {
      EAG_IDLE,
      EAG_FETCH,
      EAG_FINISH
   } eag_state_t;

   eag_state_t       state_reg, state_next;
   logic [AW-1:0]    ea_reg, ea_next;
   logic [AW-1:0]    fa_reg, fa_next;
   logic [63:0]      opnd_reg, opnd_next;
   logic             done_reg, done_next;
   logic             isreg_reg, isreg_next;
   logic             isimm_reg, isimm_next;
   logic             awr_reg, awr_next;
   logic [2:0]       anum_reg, anum_next;
   logic [31:0]      aval_reg, aval_next;
   logic [31:0]      fld_reg, fld_next;
   logic [7:0]       bcd_reg, bcd_next;
   logic             post_reg, post_next;
   logic [31:0]      post_idx_reg, post_idx_next;
   logic [31:0]      od_reg, od_next;

   logic [31:0] areg [REG_COUNT];
   logic [31:0] dreg [REG_COUNT];
   logic [31:0] idx_raw, idx_ext, idx_scaled;
   logic [31:0] sd_ext, wd_ext, bd_ext, od_ext;
   logic [31:0] base, step;

   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++) begin : g_regs
         assign areg[gi] = address_reg[gi*32 +: 32];
         assign dreg[gi] = data_reg[gi*32 +: 32];
      end
   endgenerate

   assign idx_raw    = index_sel[3] ? areg[index_sel[2:0]] : dreg[index_sel[2:0]];
   assign idx_ext    = index_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};
   assign idx_scaled = idx_ext << index_scale;

   assign sd_ext = {{24{short_disp[7]}}, short_disp};
   assign wd_ext = {{16{word_disp[15]}}, word_disp};

   assign bd_ext = (base_offset_size == EAG_OFS_LONG) ? base_offset :
                   (base_offset_size == EAG_OFS_WORD) ?
                   {{16{base_offset[15]}}, base_offset[15:0]} : 32'h0000_0000;
   assign od_ext = (outer_offset_size == EAG_OFS_LONG) ? outer_offset :
                   (outer_offset_size == EAG_OFS_WORD) ?
                   {{16{outer_offset[15]}}, outer_offset[15:0]} : 32'h0000_0000;

   // PC or address register as base
   assign base = (mode inside {EAG_PC_DISP, EAG_PC_IDX_SHORT, EAG_PC_IDX_BASE,
                  EAG_PC_MEM_POSTIDX, EAG_PC_MEM_PREIDX}) ? pc : areg[reg_num];

   // Step by operand size; byte on A7 keeps stack word aligned
   always_comb begin
      case (op_size)
         EAG_SZ_BYTE: step = (reg_num == 3'h7) ? 32'h0000_0002 : 32'h0000_0001;
         EAG_SZ_WORD: step = 32'h0000_0002;
         EAG_SZ_LONG: step = 32'h0000_0004;
         EAG_SZ_QUAD: step = 32'h0000_0008;
         default:     step = 32'h0000_0004;
      endcase
   end

   always_comb begin
      state_next    = state_reg;
      ea_next       = ea_reg;
      fa_next       = fa_reg;
      opnd_next     = opnd_reg;
      done_next     = 1'b0;
      isreg_next    = isreg_reg;
      isimm_next    = isimm_reg;
      awr_next      = 1'b0;
      anum_next     = anum_reg;
      aval_next     = aval_reg;
      fld_next      = fld_reg;
      bcd_next      = bcd_reg;
      post_next     = post_reg;
      post_idx_next = post_idx_reg;
      od_next       = od_reg;
      case (state_reg)
         EAG_IDLE: begin
            if (start) begin
               isreg_next = 1'b0;
               isimm_next = 1'b0;
               anum_next  = reg_num;
               done_next  = 1'b1;
               // Field of 1 to 32 bits from a register operand
               fld_next   = (dreg[reg_num] >> field_offset) &
                            (32'hffff_ffff >> (5'd31 - field_len_m1));
               // Packed keeps two digits, unpacked one per byte
               bcd_next   = bcd_packed ? dreg[reg_num][7:0] :
                            {4'h0, dreg[reg_num][3:0]};
               case (mode)
                  EAG_DATA_DIRECT: begin
                     isreg_next = 1'b1;
                     opnd_next  = {32'h0000_0000, dreg[reg_num]};
                  end
                  EAG_ADDR_DIRECT: begin
                     isreg_next = 1'b1;
                     opnd_next  = {32'h0000_0000, areg[reg_num]};
                  end
                  EAG_ADDR_IND: ea_next = areg[reg_num];
                  EAG_ADDR_POSTINC: begin
                     ea_next   = areg[reg_num];
                     awr_next  = 1'b1;
                     aval_next = areg[reg_num] + step;
                  end
                  EAG_ADDR_PREDEC: begin
                     ea_next   = areg[reg_num] - step;
                     awr_next  = 1'b1;
                     aval_next = areg[reg_num] - step;
                  end
                  EAG_ADDR_DISP, EAG_PC_DISP: ea_next = base + wd_ext;
                  EAG_ADDR_IDX_SHORT, EAG_PC_IDX_SHORT: ea_next = base + sd_ext + idx_scaled;
                  EAG_ADDR_IDX_BASE, EAG_PC_IDX_BASE: ea_next = base + bd_ext + idx_scaled;
                  EAG_MEM_POSTIDX, EAG_PC_MEM_POSTIDX, EAG_MEM_PREIDX, EAG_PC_MEM_PREIDX: begin
                     post_next     = (mode == EAG_MEM_POSTIDX) || (mode == EAG_PC_MEM_POSTIDX);
                     fa_next       = post_next ? base + bd_ext : base + bd_ext + idx_scaled;
                     post_idx_next = post_next ? idx_scaled : 32'h0000_0000;
                     od_next       = od_ext;
                     done_next     = 1'b0;
                     state_next    = EAG_FETCH;
                  end
                  EAG_ABS_SHORT: ea_next = {{16{ext_word[15]}}, ext_word[15:0]};
                  EAG_ABS_LONG:  ea_next = ext_word;
                  EAG_IMMEDIATE: begin
                     isimm_next = 1'b1;
                     case (op_size)
                        EAG_SZ_BYTE: opnd_next = {56'h0, ext_word[7:0]};
                        EAG_SZ_WORD: opnd_next = {48'h0, ext_word[15:0]};
                        default:     opnd_next = {32'h0000_0000, ext_word};
                     endcase
                  end
                  default: done_next = 1'b1;
               endcase
            end
         end
         EAG_FETCH: begin
            if (fetch_ack) begin
               ea_next    = fetch_data + post_idx_reg + od_reg;
               state_next = EAG_FINISH;
            end
         end
         EAG_FINISH: begin
            done_next  = 1'b1;
            state_next = EAG_IDLE;
         end
         default: state_next = EAG_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg    <= EAG_IDLE;
         ea_reg       <= ADDR_RESET;
         fa_reg       <= ADDR_RESET;
         opnd_reg     <= 64'h0;
         done_reg     <= 1'b0;
         isreg_reg    <= 1'b0;
         isimm_reg    <= 1'b0;
         awr_reg      <= 1'b0;
         anum_reg     <= 3'h0;
         aval_reg     <= 32'h0000_0000;
         fld_reg      <= 32'h0000_0000;
         bcd_reg      <= 8'h00;
         post_reg     <= 1'b0;
         post_idx_reg <= 32'h0000_0000;
         od_reg       <= 32'h0000_0000;
      end else begin
         state_reg    <= state_next;
         ea_reg       <= ea_next;
         fa_reg       <= fa_next;
         opnd_reg     <= opnd_next;
         done_reg     <= done_next;
         isreg_reg    <= isreg_next;
         isimm_reg    <= isimm_next;
         awr_reg      <= awr_next;
         anum_reg     <= anum_next;
         aval_reg     <= aval_next;
         fld_reg      <= fld_next;
         bcd_reg      <= bcd_next;
         post_reg     <= post_next;
         post_idx_reg <= post_idx_next;
         od_reg       <= od_next;
      end
   end

   assign fetch_req    = (state_reg == EAG_FETCH);
   assign fetch_addr   = fa_reg;
   assign busy         = (state_reg != EAG_IDLE);
   assign done         = done_reg;
   assign is_register  = isreg_reg;
   assign is_immediate = isimm_reg;
   assign ea           = ea_reg;
   assign operand      = opnd_reg;
   assign areg_write   = awr_reg;
   assign areg_num     = anum_reg;
   assign areg_value   = aval_reg;
   assign field_value  = fld_reg;
   assign bcd_value    = bcd_reg;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_fetch_accept;
      fetch_req && fetch_ack;
   endsequence

   a_outer_after_fetch: assert property (@(posedge clock) disable iff (reset)
      s_fetch_accept |-> ##1 (ea == $past(fetch_data) + post_idx_reg + od_reg) ##1 done)
      else $error("outer offset not applied after fetch");

   a_postinc_value: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_ADDR_POSTINC) |=>
      (areg_write && areg_value == ea + $past(step)))
      else $error("post-increment value wrong");

   a_predec_value: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_ADDR_PREDEC) |=> (areg_write && areg_value == ea))
      else $error("pre-decrement address wrong");

   a_abs_short_ext: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_ABS_SHORT) |=> (ea[31:16] == {16{ea[15]}}) && done)
      else $error("absolute short not sign extended");

   a_disp_sign: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_ADDR_DISP) |=> (ea == $past(areg[reg_num] + wd_ext)))
      else $error("displacement sum wrong");

   a_index_scale: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_ADDR_IDX_SHORT) |=>
      (ea == $past(areg[reg_num] + sd_ext + idx_scaled)))
      else $error("scaled index sum wrong");

   a_preidx_fetch: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_MEM_PREIDX) |=>
      (fetch_req && fetch_addr == $past(base + bd_ext + idx_scaled)))
      else $error("pre-indexed fetch address wrong");

   a_pc_base: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_PC_DISP) |=> (ea == $past(pc + wd_ext)))
      else $error("pc relative address wrong");

   a_imm_byte: assert property (@(posedge clock) disable iff (reset)
      (start && !busy && mode == EAG_IMMEDIATE && op_size == EAG_SZ_BYTE) |=>
      (is_immediate && operand[63:8] == 56'h0))
      else $error("byte immediate not masked");

endmodule

`default_nettype wire

/* File: rtl/eag_pkg.sv */
// Purpose: Shared constants and types for the effective address generator
// Assumes: 32-bit addresses, sixteen general registers (eight data, eight address)
// Notes:   Mode enumeration covers every addressing mode the generator resolves
package eag_pkg;

   localparam int ADDR_W      = 32;
   localparam int REG_COUNT   = 8;
   localparam int REG_SEL_W   = 4;

   // Operand size codes
   typedef enum logic [1:0] {
      EAG_SZ_BYTE,
      EAG_SZ_WORD,
      EAG_SZ_LONG,
      EAG_SZ_QUAD
   } eag_size_t;

   // Optional field widths: none, 16 bit, 32 bit
   typedef enum logic [1:0] {
      EAG_OFS_NONE,
      EAG_OFS_WORD,
      EAG_OFS_LONG
   } eag_ofs_t;

   typedef enum logic [4:0] {
      EAG_DATA_DIRECT,
      EAG_ADDR_DIRECT,
      EAG_ADDR_IND,
      EAG_ADDR_POSTINC,
      EAG_ADDR_PREDEC,
      EAG_ADDR_DISP,
      EAG_ADDR_IDX_SHORT,
      EAG_ADDR_IDX_BASE,
      EAG_MEM_POSTIDX,
      EAG_MEM_PREIDX,
      EAG_PC_DISP,
      EAG_PC_IDX_SHORT,
      EAG_PC_IDX_BASE,
      EAG_PC_MEM_POSTIDX,
      EAG_PC_MEM_PREIDX,
      EAG_ABS_SHORT,
      EAG_ABS_LONG,
      EAG_IMMEDIATE
   } eag_mode_t;

   localparam int MODE_COUNT   = 18;
   localparam int BCD_PACKED_DIGITS   = 2;
   localparam int BCD_UNPACKED_DIGITS = 1;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

endpackage

/* File: bench/eag_core_tb.sv */
// Purpose: Self-checking bench for the effective address generator
// Assumes: Bench answers the indirect fetch port one cycle after each request
// Notes:   Unpacked digits are expected in the low nibble with the high nibble clear
`timescale 1ns/100ps
`default_nettype none

module eag_core_tb
   import eag_pkg::*;
;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic              clock             = 1'b0;
   logic              reset             = 1'b1;
   logic              start             = 1'b0;
   eag_mode_t         mode              = EAG_DATA_DIRECT;
   eag_size_t         op_size           = EAG_SZ_LONG;
   logic [2:0]        reg_num           = 3'h0;
   logic [3:0]        index_sel         = 4'h0;
   logic              index_long        = 1'b0;
   logic [1:0]        index_scale       = 2'h0;
   logic [7:0]        short_disp        = 8'h00;
   logic [15:0]       word_disp         = 16'h0000;
   eag_ofs_t          base_offset_size  = EAG_OFS_NONE;
   logic [31:0]       base_offset       = 32'h0;
   eag_ofs_t          outer_offset_size = EAG_OFS_NONE;
   logic [31:0]       outer_offset      = 32'h0;
   logic [31:0]       ext_word          = 32'h0;
   logic [31:0]       pc                = 32'h0020_0000;
   logic [8*32-1:0]   data_reg;
   logic [8*32-1:0]   address_reg;
   logic [4:0]        field_offset      = 5'h00;
   logic [4:0]        field_len_m1      = 5'h1f;
   logic              bcd_packed        = 1'b0;
   logic              fetch_ack         = 1'b0;
   logic [31:0]       fetch_data        = 32'h0;
   logic              fetch_req, busy, done, is_register, is_immediate, areg_write, aw;
   logic [31:0]       fetch_addr, ea, areg_value, field_value;
   logic [63:0]       operand;
   logic [2:0]        areg_num;
   logic [7:0]        bcd_value;
   int                err_count         = 0;
   int                n_checks          = 0;
   int                cycles            = 0;

   eag_core dut_u (
      .clock, .reset, .start, .mode, .op_size, .reg_num, .index_sel, .index_long,
      .index_scale, .short_disp, .word_disp, .base_offset_size, .base_offset,
      .outer_offset_size, .outer_offset, .ext_word, .pc, .data_reg, .address_reg,
      .field_offset, .field_len_m1, .bcd_packed, .fetch_req, .fetch_addr, .fetch_ack,
      .fetch_data, .busy, .done, .is_register, .is_immediate, .ea, .operand,
      .areg_write, .areg_num, .areg_value, .field_value, .bcd_value
   );

   always #5 clock = ~clock;

   // Hang guard, far above the roughly 120 cycles the run needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count = err_count + 1;
         wrap_up();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   function automatic logic [31:0] dv(input int i);
      return (i == 3) ? 32'h1234_fff0 : 32'h0000_0010 * (i + 1);
   endfunction

   function automatic logic [31:0] av(input int i);
      return 32'h0001_0000 * (i + 1) + 32'h0000_0004;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One request; fetch answered with fd, other cycles show its inverse
   task automatic go(input eag_mode_t m, input logic [31:0] fa, input logic [31:0] fd);
      mode  <= m;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      for (int n = 0; n < 20 && done !== 1'b1; n++) begin
         @(posedge clock);
         if (fetch_req === 1'b1 && fetch_ack === 1'b0) begin
            chk(fetch_addr, fa);
            fetch_ack  <= 1'b1;
            fetch_data <= fd;
         end else begin
            fetch_ack  <= 1'b0;
            fetch_data <= ~fd;
         end
      end
      aw = areg_write;
      chk(done, 1'b1);
   endtask

   task automatic wrap_up();
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_direct();
      for (int i = 0; i < 8; i++) begin
         reg_num <= 3'(i);
         go(EAG_DATA_DIRECT, 32'h0, 32'h0);
         chk(operand[31:0], dv(i));
         chk(is_register, 1'b1);
         chk(field_value, dv(i));
         go(EAG_ADDR_DIRECT, 32'h0, 32'h0);
         chk(operand[31:0], av(i));
      end
   endtask

   task automatic t_step();
      logic [31:0] e;
      for (int s = 0; s < 4; s++) begin
         op_size <= eag_size_t'(s);
         reg_num <= 3'h1;
         go(EAG_ADDR_POSTINC, 32'h0, 32'h0);
         chk(ea, av(1));
         chk({aw, areg_num, areg_value}, {1'b1, 3'h1, av(1) + (32'h1 << s)});
         reg_num <= 3'h7;
         go(EAG_ADDR_PREDEC, 32'h0, 32'h0);
         e = av(7) - ((s == 0) ? 32'h2 : 32'h1 << s);
         chk(ea, e);
         chk({aw, areg_num, areg_value}, {1'b1, 3'h7, e});
      end
      op_size <= EAG_SZ_LONG;
      reg_num <= 3'h3;
      go(EAG_ADDR_IND, 32'h0, 32'h0);
      chk(ea, av(3));
   endtask

   task automatic t_disp();
      reg_num   <= 3'h2;
      word_disp <= 16'hff00;
      go(EAG_ADDR_DISP, 32'h0, 32'h0);
      chk(ea, av(2) - 32'h100);
      word_disp <= 16'h7ffe;
      go(EAG_PC_DISP, 32'h0, 32'h0);
      chk(ea, 32'h0020_7ffe);
   endtask

   task automatic t_index();
      for (int sc = 0; sc < 4; sc++) begin
         reg_num     <= 3'h1;
         short_disp  <= 8'h80;
         index_sel   <= 4'h3;
         index_long  <= 1'b0;
         index_scale <= 2'(sc);
         go(EAG_ADDR_IDX_SHORT, 32'h0, 32'h0);
         chk(ea, av(1) - 32'h80 - (32'h10 << sc));
         go(EAG_PC_IDX_SHORT, 32'h0, 32'h0);
         chk(ea, pc - 32'h80 - (32'h10 << sc));
      end
      reg_num          <= 3'h0;
      index_sel        <= 4'hc;
      index_long       <= 1'b1;
      index_scale      <= 2'h2;
      base_offset_size <= EAG_OFS_WORD;
      base_offset      <= 32'h1234_8000;
      go(EAG_ADDR_IDX_BASE, 32'h0, 32'h0);
      chk(ea, av(0) - 32'h8000 + (av(4) << 2));
      base_offset_size <= EAG_OFS_LONG;
      base_offset      <= 32'h0100_0000;
      go(EAG_PC_IDX_BASE, 32'h0, 32'h0);
      chk(ea, pc + 32'h0100_0000 + (av(4) << 2));
      base_offset_size <= EAG_OFS_NONE;
      go(EAG_ADDR_IDX_BASE, 32'h0, 32'h0);
      chk(ea, av(0) + (av(4) << 2));
   endtask

   task automatic t_mem();
      reg_num           <= 3'h2;
      index_sel         <= 4'h1;
      index_scale       <= 2'h1;
      base_offset_size  <= EAG_OFS_WORD;
      base_offset       <= 32'h0000_0010;
      outer_offset_size <= EAG_OFS_LONG;
      outer_offset      <= 32'h0000_0100;
      go(EAG_MEM_PREIDX, av(2) + 32'h10 + (dv(1) << 1), 32'h0040_0000);
      chk(ea, 32'h0040_0100);
      outer_offset_size <= EAG_OFS_WORD;
      outer_offset      <= 32'habcd_fffc;
      go(EAG_MEM_POSTIDX, av(2) + 32'h10, 32'h0040_0000);
      chk(ea, 32'h0040_0000 + (dv(1) << 1) - 32'h4);
      go(EAG_PC_MEM_POSTIDX, pc + 32'h10, 32'h0050_0000);
      chk(ea, 32'h0050_0000 + (dv(1) << 1) - 32'h4);
      outer_offset_size <= EAG_OFS_NONE;
      go(EAG_PC_MEM_PREIDX, pc + 32'h10 + (dv(1) << 1), 32'h0060_0000);
      chk(ea, 32'h0060_0000);
   endtask

   task automatic t_abs();
      logic [31:0] m;
      ext_word <= 32'h1234_8004;
      go(EAG_ABS_SHORT, 32'h0, 32'h0);
      chk(ea, 32'hffff_8004);
      ext_word <= 32'h0000_7ffc;
      go(EAG_ABS_SHORT, 32'h0, 32'h0);
      chk(ea, 32'h0000_7ffc);
      ext_word <= 32'h8765_4321;
      go(EAG_ABS_LONG, 32'h0, 32'h0);
      chk(ea, 32'h8765_4321);
      for (int s = 0; s < 4; s++) begin
         op_size <= eag_size_t'(s);
         m = (s >= 2) ? 32'hffff_ffff : (32'h1 << (8 << s)) - 32'h1;
         go(EAG_IMMEDIATE, 32'h0, 32'h0);
         chk({is_immediate, is_register}, 2'b10);
         chk(operand, {32'h0000_0000, 32'h8765_4321 & m});
      end
   endtask

   task automatic t_typing();
      reg_num      <= 3'h3;
      field_offset <= 5'h08;
      field_len_m1 <= 5'h0b;
      go(EAG_DATA_DIRECT, 32'h0, 32'h0);
      chk(field_value, 32'h0000_04ff);
      reg_num      <= 3'h1;
      field_offset <= 5'h05;
      field_len_m1 <= 5'h00;
      bcd_packed   <= 1'b1;
      go(EAG_DATA_DIRECT, 32'h0, 32'h0);
      chk(field_value, 32'h0000_0001);
      chk(bcd_value, 8'h20);
      bcd_packed   <= 1'b0;
      go(EAG_DATA_DIRECT, 32'h0, 32'h0);
      chk(bcd_value, 8'h00);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      for (int i = 0; i < 8; i++) begin
         data_reg[i*32+:32]    = dv(i);
         address_reg[i*32+:32] = av(i);
      end
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      chk({busy, done, ea}, {2'b00, ADDR_RESET});
      t_direct();
      t_step();
      t_disp();
      t_index();
      t_mem();
      t_abs();
      t_typing();
      wrap_up();
   end

endmodule

`default_nettype wire
